//--- hdl/cad_regs.svh
// Offsets, field positions, reset values for the config access decoder
`ifndef CAD_REGS_SVH
`define CAD_REGS_SVH
`define CAD_IO_CFG_ADDR 16'h0CF8
`define CAD_IO_CFG_DATA 16'h0CFC
`define CAD_CFG_ADDR_RST 32'h00000000
`define CAD_CFG_ADDR_WMASK 32'h80FFFFFC
`define CAD_CFG_EN_BIT 31
`define CAD_BAR_IDX 6'h05
`define CAD_BUSNUM_IDX 6'h06
`define CAD_SECSTAT_IDX 6'h07
`define CAD_ABORT_BIT 29
`define CAD_BAR_MASK 32'hFFFFF000
`define CAD_MEM_WIDTH_OFS 12'h02C
`define CAD_ROW_WIDTH_RST 4'h0
`define CAD_BAR_RST 32'h00000000
`define CAD_BUS_RST 8'h00
`define CAD_CLK_PAIR_RST 6'h00
`define CAD_TYPE1_CODE 2'h1
`define CAD_ALL_ONES 32'hFFFFFFFF
`endif

//--- hdl/cad_pkg.sv
// Types shared by the config access decoder
package cad_pkg;
  typedef struct packed {
    logic req;
    logic write;
    logic isMem;
    logic [31:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } cad_host_req_t;
  typedef struct packed {
    logic valid;
    logic toGraphics;
    logic type1;
    logic write;
    logic [31:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } cad_cfg_cycle_t;
  typedef enum logic [2:0] {
    CAD_ST_IDLE = 3'b001,
    CAD_ST_EXT = 3'b010,
    CAD_ST_RESP = 3'b100
  } cad_state_t;
endpackage

//--- hdl/cad_config_access.sv
// Config address decode, data window routing and memory-mapped control registers
`timescale 1ns/1ps
`include "cad_regs.svh"
module cad_config_access (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cad_pkg::cad_host_req_t hostReq,
  output logic hostAck,
  output logic [31:0] hostRdata,
  input wire logic barReveal,
  output cad_pkg::cad_cfg_cycle_t cfgCycle,
  input wire logic extDone,
  input wire logic [31:0] extRdata,
  output logic [5:0] clkPairX8
);
  import cad_pkg::*;

  // Builds the outgoing configuration address
  function automatic logic [31:0] cfgAddrBuild(input logic [31:0] ca, input logic gfxType0, input logic type1);
    logic [15:0] idsel;
    idsel = 16'h0000;
    if (!ca[15]) begin
      idsel = 16'h0001 << ca[14:11];
    end
    if (gfxType0) begin
      cfgAddrBuild = {idsel, 5'h00, ca[10:2], 2'h0};
    end else begin
      cfgAddrBuild = {8'h00, ca[23:11], ca[10:2], type1 ? `CAD_TYPE1_CODE : 2'h0};
    end
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    laneMerge = old;
  endfunction

  cad_state_t state_r, state_nxt;
  logic [31:0] cfgAddr_r, cfgAddr_nxt;
  logic [31:0] barBase_r, barBase_nxt;
  logic [7:0] secBus_r, secBus_nxt;
  logic [7:0] subBus_r, subBus_nxt;
  logic abort_r, abort_nxt;
  logic [3:0] rowWidth_r, rowWidth_nxt;
  logic [5:0] clkX8_r, clkX8_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  cad_cfg_cycle_t cyc_r, cyc_nxt;
  logic [7:0] busF;
  logic [4:0] devF;
  logic [2:0] fnF;
  logic [5:0] regF;
  logic isInternal, isGfxT0, isGfxT1;
  logic take, ioCfgAddr, ioCfgData, cfgEn, memHit;
  logic widthHit;

  // Field split of the config address
  assign busF = cfgAddr_r[23:16];
  assign devF = cfgAddr_r[15:11];
  assign fnF = cfgAddr_r[10:8];
  assign regF = cfgAddr_r[7:2];
  assign cfgEn = cfgAddr_r[`CAD_CFG_EN_BIT];
  assign isInternal = (busF == 8'h00) && (devF < 5'h02);
  assign isGfxT0 = (busF != 8'h00) && (busF == secBus_r);
  assign isGfxT1 = (busF != 8'h00) && (busF > secBus_r) && (busF <= subBus_r);
  assign take = hostReq.req && (state_r == CAD_ST_IDLE);
  assign ioCfgAddr = !hostReq.isMem && (hostReq.addr[15:0] == `CAD_IO_CFG_ADDR);
  assign ioCfgData = !hostReq.isMem && (hostReq.addr[15:0] == `CAD_IO_CFG_DATA);
  assign memHit = hostReq.isMem && barReveal &&
    ((hostReq.addr & `CAD_BAR_MASK) == (barBase_r & `CAD_BAR_MASK));
  // Row width register picked out of the revealed window
  assign widthHit = hostReq.addr[11:2] == 10'(`CAD_MEM_WIDTH_OFS >> 2);

  // Next values of all block state
  always_comb begin
    state_nxt = state_r;
    cfgAddr_nxt = cfgAddr_r;
    barBase_nxt = barBase_r;
    secBus_nxt = secBus_r;
    subBus_nxt = subBus_r;
    abort_nxt = abort_r;
    rowWidth_nxt = rowWidth_r;
    rdata_nxt = rdata_r;
    cyc_nxt = cyc_r;
    cyc_nxt.valid = 1'b0;
    unique case (state_r)
      CAD_ST_IDLE: begin
        if (take) begin
          state_nxt = CAD_ST_RESP;
          rdata_nxt = 32'h00000000;
          // Config address port
          if (ioCfgAddr) begin
            // Reserved bits masked on write
            if (hostReq.write && (hostReq.byteEn == 4'hF)) begin
              cfgAddr_nxt = hostReq.wdata & `CAD_CFG_ADDR_WMASK;
            end
            rdata_nxt = cfgAddr_r;
          end else if (ioCfgData && cfgEn) begin
            // Internal bridge registers, claimed here
            if (isInternal) begin
              if (fnF != 3'h0) begin
                rdata_nxt = `CAD_ALL_ONES;
              end else if (devF == 5'h00 && regF == `CAD_BAR_IDX) begin
                // Base register hidden until revealed
                rdata_nxt = barReveal ? barBase_r : 32'h00000000;
                if (hostReq.write && barReveal) begin
                  barBase_nxt = laneMerge(barBase_r, hostReq.wdata, hostReq.byteEn) & `CAD_BAR_MASK;
                end
              end else if (devF == 5'h01 && regF == `CAD_BUSNUM_IDX) begin
                // Secondary and subordinate bus numbers
                rdata_nxt = {8'h00, subBus_r, secBus_r, 8'h00};
                if (hostReq.write && hostReq.byteEn[1]) begin
                  secBus_nxt = hostReq.wdata[15:8];
                end
                if (hostReq.write && hostReq.byteEn[2]) begin
                  subBus_nxt = hostReq.wdata[23:16];
                end
              end else if (devF == 5'h01 && regF == `CAD_SECSTAT_IDX) begin
                // Received abort flag, write one clears
                rdata_nxt[`CAD_ABORT_BIT] = abort_r;
                if (hostReq.write && hostReq.byteEn[3] && hostReq.wdata[`CAD_ABORT_BIT]) begin
                  abort_nxt = 1'b0; // Write one clears
                end
              end
            end else begin
              // External cycle toward graphics port or hub
              state_nxt = CAD_ST_EXT;
              cyc_nxt.valid = 1'b1;
              cyc_nxt.toGraphics = isGfxT0 || isGfxT1;
              cyc_nxt.type1 = !isGfxT0 && (busF != 8'h00);
              cyc_nxt.write = hostReq.write;
              cyc_nxt.byteEn = hostReq.byteEn;
              cyc_nxt.wdata = hostReq.wdata;
              cyc_nxt.addr = cfgAddrBuild(cfgAddr_r, isGfxT0, cyc_nxt.type1);
              if (isGfxT0 && devF[4]) begin
                abort_nxt = 1'b1;
              end
            end
          end else if (memHit) begin
            // Only the 4-bit row width field is backed; the rest reads zero
            if (widthHit) begin
              rdata_nxt = {28'h0000000, rowWidth_r};
              if (hostReq.write && hostReq.byteEn[0]) begin
                rowWidth_nxt = hostReq.wdata[3:0];
              end
            end
          end
        end
      end
      CAD_ST_EXT: begin
        if (extDone) begin
          rdata_nxt = extRdata;
          state_nxt = CAD_ST_RESP;
        end
      end
      CAD_ST_RESP: begin
        state_nxt = CAD_ST_IDLE;
      end
      default: begin
        state_nxt = CAD_ST_IDLE;
      end
    endcase
    // Clock pair width select per row pair
    clkX8_nxt = {{3{rowWidth_nxt[2] | rowWidth_nxt[3]}}, {3{rowWidth_nxt[0] | rowWidth_nxt[1]}}};
  end

  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= CAD_ST_IDLE;
      cfgAddr_r <= `CAD_CFG_ADDR_RST;
      barBase_r <= `CAD_BAR_RST;
      secBus_r <= `CAD_BUS_RST;
      subBus_r <= `CAD_BUS_RST;
      abort_r <= 1'b0;
      rowWidth_r <= `CAD_ROW_WIDTH_RST;
      clkX8_r <= `CAD_CLK_PAIR_RST;
      rdata_r <= 32'h00000000;
      cyc_r <= '0;
    end else begin
      state_r <= state_nxt;
      cfgAddr_r <= cfgAddr_nxt;
      barBase_r <= barBase_nxt;
      secBus_r <= secBus_nxt;
      subBus_r <= subBus_nxt;
      abort_r <= abort_nxt;
      rowWidth_r <= rowWidth_nxt;
      clkX8_r <= clkX8_nxt;
      rdata_r <= rdata_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // Outputs
  assign hostAck = (state_r == CAD_ST_RESP);
  assign hostRdata = rdata_r;
  assign cfgCycle = cyc_r;
  assign clkPairX8 = clkX8_r;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  cfg_reserved_a: assert property (cfgAddr_r[30:24] == 7'h00 && cfgAddr_r[1:0] == 2'h0)
    else $error("reserved config address bits not zero");
  idsel_decode_a: assert property (cyc_r.valid && cyc_r.toGraphics && !cyc_r.type1 && !devF[4]
    |-> cyc_r.addr[31:16] == (16'h0001 << devF[3:0]))
    else $error("IDSEL line does not match device");
  no_idsel_a: assert property (cyc_r.valid && cyc_r.toGraphics && !cyc_r.type1 && devF[4]
    |-> cyc_r.addr[31:16] == 16'h0000 && abort_r)
    else $error("high device number drove IDSEL or no abort");
  dev_pass_a: assert property (cyc_r.valid && cyc_r.type1 |-> cyc_r.addr[15:11] == devF)
    else $error("device field not passed through");
  fn_reg_a: assert property (cyc_r.valid |-> cyc_r.addr[10:2] == cfgAddr_r[10:2])
    else $error("function or register field wrong");
  window_gate_a: assert property (take && ioCfgData && !cfgEn
    |=> !cyc_r.valid && hostAck ##1 !hostAck)
    else $error("disabled window produced a cycle");
  internal_claim_a: assert property (take && ioCfgData && cfgEn && isInternal
    |=> !cyc_r.valid && hostAck)
    else $error("internal access left the block");
  fn_ignore_a: assert property (take && ioCfgData && cfgEn && isInternal && fnF != 3'h0
    |=> hostRdata == `CAD_ALL_ONES && $stable(barBase_r))
    else $error("nonzero function not ignored");
  bar_hidden_a: assert property (take && ioCfgData && cfgEn && isInternal && fnF == 3'h0 && devF == 5'h00 &&
    regF == `CAD_BAR_IDX && !barReveal |=> hostRdata == 32'h00000000)
    else $error("hidden base register read nonzero");
  route_type_a: assert property (take && ioCfgData && cfgEn && !isInternal
    |=> cyc_r.valid && cyc_r.toGraphics == $past(isGfxT0 || isGfxT1))
    else $error("config cycle routed to wrong port");
  row_clock_a: assert property (##1 clkPairX8[0] == ($past(rowWidth_nxt[0]) | $past(rowWidth_nxt[1])))
    else $error("clock pair width select wrong");
  width_write_a: assert property (take && memHit && hostReq.write && hostReq.byteEn[0] &&
    widthHit |=> rowWidth_r == $past(hostReq.wdata[3:0]))
    else $error("row width write lost");

  // Routing of cycles that leave the block, and the config address write
  hub_route_a: assert property (take && ioCfgData && cfgEn && busF == 8'h00 && devF >= 5'h02
    |=> cyc_r.valid && !cyc_r.toGraphics && !cyc_r.type1 && cyc_r.addr[15:11] == devF)
    else $error("bus zero device cycle not sent to hub");
  gfx_type0_a: assert property (take && ioCfgData && cfgEn && busF != 8'h00 && busF == secBus_r
    |=> cyc_r.valid && cyc_r.toGraphics && !cyc_r.type1)
    else $error("secondary bus access not sent as graphics type 0");
  gfx_type1_a: assert property (take && ioCfgData && cfgEn && busF > secBus_r && busF <= subBus_r
    |=> cyc_r.valid && cyc_r.toGraphics && cyc_r.type1 && cyc_r.addr[23:16] == busF)
    else $error("bus in range not sent as graphics type 1");
  data_pass_a: assert property (take && ioCfgData && cfgEn && !isInternal && hostReq.write
    |=> cyc_r.write && cyc_r.wdata == $past(hostReq.wdata))
    else $error("window write data not carried to cycle");
  cfg_write_a: assert property (take && ioCfgAddr && hostReq.write && hostReq.byteEn == 4'hF
    |=> cfgAddr_r[31] == $past(hostReq.wdata[31]) && cfgAddr_r[23:2] == $past(hostReq.wdata[23:2]))
    else $error("config address write not stored");
  // Memory-mapped control space
  mem_hidden_a: assert property (take && hostReq.isMem && !barReveal
    |=> hostRdata == 32'h00000000)
    else $error("hidden control space answered");
  bar_align_a: assert property (barBase_r != 32'h00000000
    |-> barBase_r[11:0] == 12'h000)
    else $error("base register low bits not zero");
  mem_reserved_a: assert property (take && memHit && !widthHit
    |=> hostRdata == 32'h00000000)
    else $error("reserved control offset read nonzero");
  width_rsvd_a: assert property (take && memHit && widthHit
    |=> hostRdata[31:4] == 28'h0000000)
    else $error("row width reserved bits nonzero");
  pair_map_a: assert property (clkPairX8[2:0] == {3{rowWidth_r[0] | rowWidth_r[1]}} &&
    clkPairX8[5:3] == {3{rowWidth_r[2] | rowWidth_r[3]}})
    else $error("clock pair select does not follow row widths");
  // Hold and pulse behaviour
  addr_hold_a: assert property (state_r != CAD_ST_IDLE
    |=> $stable(cfgAddr_r))
    else $error("config address moved during an access");
  ack_pulse_a: assert property (hostAck
    |=> !hostAck)
    else $error("acknowledge longer than one cycle");
  abort_hold_a: assert property (abort_r && !take
    |=> abort_r)
    else $error("abort flag lost without a clear");

  ext_cycle_c: cover property (cyc_r.valid && cyc_r.type1 ##[1:20] hostAck);
  gfx_type0_c: cover property (cyc_r.valid && cyc_r.toGraphics && !cyc_r.type1);
  width_write_c: cover property (take && memHit && hostReq.write);
  abort_set_c: cover property ($rose(abort_r));
  window_off_c: cover property (take && ioCfgData && !cfgEn);
endmodule

//--- testbench/cad_ext_model.sv
// External cycle responder for the config access decoder
`timescale 1ns/1ps
module cad_ext_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cad_pkg::cad_cfg_cycle_t cfgCycle,
  output logic extDone,
  output logic [31:0] extRdata,
  output cad_pkg::cad_cfg_cycle_t seenCycle,
  output int nSeen
);
  import cad_pkg::*;
  logic [1:0] waitCnt;
  logic busy;
  // Capture each cycle, finish it after 0 to 3 extra cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extDone <= 1'b0;
      extRdata <= 32'h0;
      seenCycle <= '0;
      nSeen <= 0;
      busy <= 1'b0;
      waitCnt <= 2'h0;
    end else begin
      extDone <= 1'b0;
      extRdata <= extRdata + 32'h1; // Data line changes outside the done cycle
      if (cfgCycle.valid) begin
        seenCycle <= cfgCycle;
        nSeen <= nSeen + 1;
        busy <= 1'b1;
        waitCnt <= cfgCycle.addr[3:2];
      end else if (busy && waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
      end else if (busy) begin
        extDone <= 1'b1;
        extRdata <= seenCycle.addr ^ 32'hA5A5A5A5;
        busy <= 1'b0;
      end
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the config access decoder
`timescale 1ns/1ps
`include "cad_regs.svh"
module tb;
  import cad_pkg::*;
  localparam logic [7:0] SEC = 8'h01;
  localparam logic [7:0] SUB = 8'h03;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic barReveal = 1'b0;
  cad_host_req_t hostReq = '0;
  logic hostAck, extDone;
  logic [31:0] hostRdata, extRdata, rd;
  logic [33:0] ex;
  logic [5:0] clkPairX8;
  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] fn;
  logic [5:0] rg;
  logic [3:0] w;
  cad_cfg_cycle_t cfgCycle, seenCycle;
  int nSeen, n, n_errors = 0, n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  cad_config_access DUT (.ref_clk(ref_clk), .rst(rst), .hostReq(hostReq), .hostAck(hostAck),
    .hostRdata(hostRdata), .barReveal(barReveal), .cfgCycle(cfgCycle), .extDone(extDone),
    .extRdata(extRdata), .clkPairX8(clkPairX8));
  cad_ext_model ext (.ref_clk(ref_clk), .rst(rst), .cfgCycle(cfgCycle), .extDone(extDone),
    .extRdata(extRdata), .seenCycle(seenCycle), .nSeen(nSeen));
  // Verdict and end of run
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One host access, held until the acknowledge cycle
  task automatic acc(input logic wr, input logic mem, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(negedge ref_clk);
    hostReq = '{1'b1, wr, mem, a, 4'hF, d};
    for (i = 0; i < 50 && hostAck !== 1'b1; i++) @(negedge ref_clk);
    if (i == 50) begin
      n_errors++;
      test_done();
    end
    rd = hostRdata;
    hostReq.req = 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] b, input logic [4:0] dv, input logic [2:0] f,
    input logic [5:0] r);
    return {8'h80, b, dv, f, r, 2'b00};
  endfunction
  // Expected route {toGraphics, type1} and external address
  function automatic logic [33:0] route(input logic [7:0] b, input logic [4:0] dv, input logic [2:0] f,
    input logic [5:0] r);
    logic [31:0] lo;
    lo = {8'h00, b, dv, f, r, 2'b00};
    if (b == SEC) return {2'b10, (dv < 16 ? 32'h1 << (16 + dv) : 32'h0) | {21'h0, f, r, 2'b00}};
    if (b > SEC && b <= SUB) return {2'b11, lo | 32'h1};
    if (b != 8'h00) return {2'b01, lo | 32'h1};
    return {2'b00, lo};
  endfunction
  initial begin
    void'($urandom(32'h98110ff1));
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk("clock pairs", {26'h0, clkPairX8}, 32'h0);
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("window off", rd, 32'h0);
    acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, 32'h7F000003);
    acc(1'b0, 1'b0, `CAD_IO_CFG_ADDR, 32'h0);
    chk("config address", rd, 32'h0);
    acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, cfg(8'h00, 5'd1, 3'd0, 6'h06));
    acc(1'b1, 1'b0, `CAD_IO_CFG_DATA, {8'h00, SUB, SEC, 8'h00});
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("bus numbers", rd, {8'h00, SUB, SEC, 8'h00});
    chk("no cycle", nSeen, 0);
    // Random config reads and a final write, first ones aimed past the last IDSEL
    for (int k = 0; k < 40; k++) begin
      bus = 8'($urandom_range(5));
      dev = k < 3 ? 5'(16 + k * 7) : 5'($urandom);
      bus = k < 3 ? SEC : bus;
      fn = 3'($urandom);
      rg = 6'($urandom);
      n = nSeen;
      acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, cfg(bus, dev, fn, rg));
      acc(k == 39, 1'b0, `CAD_IO_CFG_DATA, 32'h5A5A0000);
      ex = route(bus, dev, fn, rg);
      if (bus == 8'h00 && dev < 5'd2) begin
        chk("internal cycle count", nSeen, n);
        if (fn != 3'd0) chk("nonzero function", rd, 32'hFFFFFFFF);
      end else begin
        chk("cycle count", nSeen, n + 1);
        chk("cycle addr", seenCycle.addr, ex[31:0]);
        chk("cycle route", {30'h0, seenCycle.toGraphics, seenCycle.type1}, {30'h0, ex[33:32]});
        if (k != 39) chk("read data", rd, ex[31:0] ^ 32'hA5A5A5A5);
        if (k == 39) chk("write data", seenCycle.wdata, 32'h5A5A0000);
        chk("cycle write", {31'h0, seenCycle.write}, {31'h0, k == 39});
        chk("cycle lanes", {28'h0, seenCycle.byteEn}, 32'h0000000F);
      end
    end
    acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, cfg(8'h00, 5'd1, 3'd0, 6'h07));
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("abort flag", {31'h0, rd[29]}, 32'h1);
    acc(1'b1, 1'b0, `CAD_IO_CFG_DATA, 32'h20000000);
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("abort cleared", {31'h0, rd[29]}, 32'h0);
    // Memory-mapped control space through the base register
    barReveal = 1'b1;
    acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, cfg(8'h00, 5'd0, 3'd0, 6'h05));
    acc(1'b1, 1'b0, `CAD_IO_CFG_DATA, 32'h12345678);
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("base register", rd, 32'h12345000);
    for (int k = 0; k < 16; k++) begin
      w = 4'(k);
      acc(1'b1, 1'b1, 32'h1234502C, {28'($urandom), w});
      acc(1'b0, 1'b1, 32'h1234502C, 32'h0);
      chk("row width", rd, {28'h0, w});
      chk("clock pairs", {26'h0, clkPairX8}, {26'h0, {3{w[2] | w[3]}}, {3{w[0] | w[1]}}});
    end
    acc(1'b0, 1'b1, 32'h12345040, 32'h0);
    chk("reserved offset", rd, 32'h0);
    barReveal = 1'b0;
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("hidden base", rd, 32'h0);
    n = nSeen;
    acc(1'b1, 1'b0, `CAD_IO_CFG_ADDR, cfg(8'h00, 5'd4, 3'd0, 6'h01) & 32'h7FFFFFFF);
    acc(1'b0, 1'b0, `CAD_IO_CFG_DATA, 32'h0);
    chk("disabled window", rd, 32'h0);
    chk("disabled no cycle", nSeen, n);
    test_done();
  end
endmodule
